//--- src/tpp_consts.svh
`ifndef TPP_CONSTS_SVH
`define TPP_CONSTS_SVH

// Host I/O register addresses
`define TPP_ADDR_CTRL     2'h0
`define TPP_ADDR_SER      2'h1
`define TPP_ADDR_KBD      2'h2
`define TPP_ADDR_RLE      2'h3

// Control bits 7:4 after reset: both chip selects released
`define TPP_CTRL_RST      4'h3
// Positions of the stored control bits inside the 4-bit field
`define TPP_CTRL_MUTE     3
`define TPP_CTRL_FAST     2
`define TPP_CTRL_CS_FLASH 1
`define TPP_CTRL_CS_CARD  0

// Run-length timer: reload once the count is at or below this
`define TPP_RLE_LAST      7'h01

// Video timing
`define TPP_HC_PRESET     10'h390
`define TPP_HC_FETCH_END  10'h1f0
`define TPP_HC_LAST_PAIR  9'h1ff
`define TPP_HC_BLANK_BIT  9
`define TPP_HC_AHEAD      10'h002
`define TPP_SEG_LAST      3'h7
`define TPP_VC_PRESET     10'h000
`define TPP_VC_VIS_END    10'h180
`define TPP_VID_BASE      3'h7
`define TPP_GEN_BASE      3'h0
`define TPP_CHAR_MIN      7'h20

// Serial clock prescaler: one half period of the slow clock
`define TPP_PRESC_MAX     7'h7f
`define TPP_SER_START     8'hff

`endif

//--- src/tpp_pkg.sv
`include "tpp_consts.svh"

package tpp_pkg;

    // Register state of the peripheral set, apart from the scancode buffer
    typedef struct packed {
        logic [2:0]  tape_sy;
        logic [2:0]  tick_sy;
        logic [2:0]  hs_sy;
        logic [1:0]  vs_sy;
        logic [1:0]  motor_sy;
        logic [1:0]  miso_sy;
        logic [7:0]  rdata;
        logic [3:0]  ctrl;
        logic [7:0]  rle_in;
        logic [7:0]  rle_out;
        logic [6:0]  rle_cnt;
        logic        tape_lvl;
        logic        irq;
        logic [9:0]  hc;
        logic [9:0]  vc;
        logic [7:0]  chr;
        logic [7:0]  shift;
        logic [12:0] addr;
        logic        vrd;
        logic        blank;
        logic        ven;
        logic        hil;
        logic [7:0]  sdat;
        logic [7:0]  sctl;
        logic [6:0]  presc;
        logic        sck;
        logic        samp;
        logic        mosi;
    } tpp_state_s;

    localparam tpp_state_s TPP_STATE_RST = '{
        ctrl    : `TPP_CTRL_RST,
        blank   : 1'b1,
        default : '0
    };

endpackage

//--- src/tpp_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module tpp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_data,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
        logic                        rdy;
        logic                        vld;
    } tpp_fifo_s;

    localparam tpp_fifo_s FIFO_RST = '{rdy: 1'b1, default: '0};

    tpp_fifo_s r;
    tpp_fifo_s n;
    logic      push;
    logic      pop;

    // Pointer and count update; ready and valid are kept as flops
    always_comb begin
        n    = r;
        push = in_valid & r.rdy;
        pop  = out_ready & r.vld;
        if (push) begin
            n.mem[r.wp] = in_data;
            n.wp        = r.wp + AW'(1);
        end
        if (pop) begin
            n.rp = r.rp + AW'(1);
        end
        n.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
        n.rdy = n.cnt != (AW+1)'(DEPTH);
        n.vld = n.cnt != '0;
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r <= FIFO_RST;
        end else begin
            r <= n;
        end
    end

    assign in_ready  = r.rdy;
    assign out_valid = r.vld;
    assign out_data  = r.mem[r.rp];

endmodule

`default_nettype wire

//--- src/tpp_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "tpp_consts.svh"

// What this block does
// - Playback: count down, reload and interrupt at one or below
// - Record: edge captures level and count, reloads
// - Byte holds level bit 7, ticks below
// - Sync inputs preset internal video counters
// - Sync loads 912; wrap to zero unblanks
// - Two-cycle read strobe per character segment
// - First fetch: 111, row bits, column bits
// - Second fetch: 000, character code, line bits
// - Shift every other clock; lines doubled
// - Codes below 32 switch overlay off
// - Character top bit selects highlight colour
// - Serial mode 0 with extra input sampler
// - Serial clock fast or divided by 256
// - Data write starts eight-clock busy transfer
// - Address bits pick one of four registers
// - Control bits 7:4 read back; status below
// - Mute bit silences the companion keyboard
// - Select bits drive active-low chip selects
// - Scancode flag set while codes are queued, clears when reads drain the queue
module tpp_top
    import tpp_pkg::*;
#(
    parameter int KBD_DEPTH = 16
) (
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic [1:0]  io_addr,
    input  wire logic [7:0]  io_wdata,
    input  wire logic        io_wr,
    input  wire logic        io_rd,
    output logic      [7:0]  io_rdata,
    output logic             rle_irq,
    output logic             vid_read,
    output logic      [12:0] mem_addr,
    input  wire logic [7:0]  mem_rdata,
    input  wire logic        horiz_sync_in,
    input  wire logic        vert_sync_in,
    output logic             blanking,
    output logic             overlay_video_on,
    output logic             pixel_out,
    output logic             highlight_out,
    input  wire logic        sample_tick_in,
    input  wire logic        tape_in,
    output logic             tape_out,
    input  wire logic        motor_in,
    input  wire logic        miso_in,
    output logic             sck_out,
    output logic             mosi_out,
    output logic             flash_select_n,
    output logic             card_select_n,
    output logic             kbd_mute,
    input  wire logic [7:0]  kbd_code,
    input  wire logic        kbd_code_valid,
    output logic             kbd_code_ready
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    tpp_state_s r;
    tpp_state_s n;
    logic       scancode_valid;
    logic [7:0] fifo_data;
    logic       kbd_pop;

    // Unsigned compare used by several decoders
    function automatic logic below(input logic [9:0] a,
                                   input logic [9:0] b);
        below = a < b;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Scancode buffer

    // Keyboard read pops the oldest scancode
    assign kbd_pop = io_rd & (io_addr == `TPP_ADDR_KBD);

    tpp_fifo #(
        .WIDTH (8),
        .DEPTH (KBD_DEPTH)
    ) u_kbd_fifo (
        .clk       (mclk),
        .rst       (sys_rst),
        .in_valid  (kbd_code_valid),
        .in_data   (kbd_code),
        .in_ready  (kbd_code_ready),
        .out_valid (scancode_valid),
        .out_data  (fifo_data),
        .out_ready (kbd_pop)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb begin
        logic        tape_edge;
        logic        tick;
        logic        hs;
        logic        hs_rise;
        logic        vis_row;
        logic        fetch;
        logic [9:0]  seg;
        logic        ser_tick;
        logic        busy;

        n         = r;
        tape_edge = 1'b0;
        tick      = 1'b0;
        hs        = 1'b0;
        hs_rise   = 1'b0;
        vis_row   = 1'b0;
        fetch     = 1'b0;
        seg       = '0;
        ser_tick  = 1'b0;
        busy      = r.sctl[7];

        // Pin synchronisers: first stage feeds only the second
        n.tape_sy  = {r.tape_sy[1:0], tape_in};
        n.tick_sy  = {r.tick_sy[1:0], sample_tick_in};
        n.hs_sy    = {r.hs_sy[1:0], horiz_sync_in};
        n.vs_sy    = {r.vs_sy[0], vert_sync_in};
        n.motor_sy = {r.motor_sy[0], motor_in};
        n.miso_sy  = {r.miso_sy[0], miso_in};

        tape_edge = r.tape_sy[2] ^ r.tape_sy[1];
        tick      = r.tick_sy[1] & ~r.tick_sy[2];
        hs        = r.hs_sy[1];
        hs_rise   = r.hs_sy[1] & ~r.hs_sy[2];

        // Host register writes
        if (io_wr) begin
            if (io_addr == `TPP_ADDR_CTRL) begin
                n.ctrl = io_wdata[7:4];
            end else if (io_addr == `TPP_ADDR_SER) begin
                n.sdat  = io_wdata;
                n.sctl  = `TPP_SER_START;
                n.presc = '0;
                n.sck   = 1'b0;
                n.mosi  = io_wdata[7];
            end else if (io_addr == `TPP_ADDR_RLE) begin
                n.rle_in = io_wdata;
                n.irq    = 1'b0;
            end
        end

        // Host register reads, answered one cycle later
        if (io_rd) begin
            if (io_addr == `TPP_ADDR_CTRL) begin
                n.rdata = {r.ctrl, 1'b0, r.motor_sy[1], busy,
                           scancode_valid};
            end else if (io_addr == `TPP_ADDR_SER) begin
                n.rdata = r.sdat;
            end else if (io_addr == `TPP_ADDR_KBD) begin
                n.rdata = fifo_data;
            end else begin
                n.rdata = r.rle_out;
                n.irq   = 1'b0;
            end
        end

        ////////////////////////////////////////////////////////////////////
        // Run-length timer; a set here overrides the host clear above

        if (tape_edge) begin
            n.rle_out  = {r.tape_sy[1], r.rle_cnt};
            n.rle_cnt  = r.rle_in[6:0];
            n.tape_lvl = r.rle_in[7];
            n.irq      = 1'b1;
        end else if (tick) begin
            if (r.rle_cnt <= `TPP_RLE_LAST) begin
                n.rle_cnt  = r.rle_in[6:0];
                n.tape_lvl = r.rle_in[7];
                n.irq      = 1'b1;
            end else begin
                n.rle_cnt = r.rle_cnt - 7'h01;
            end
        end

        ////////////////////////////////////////////////////////////////////
        // Slave video counters

        // Vertical sync presets, each line start advances
        if (r.vs_sy[1]) begin
            n.vc = `TPP_VC_PRESET;
        end else if (hs_rise) begin
            n.vc = r.vc + 10'h001;
        end

        // Horizontal sync holds the count at its preset
        if (hs) begin
            n.hc = `TPP_HC_PRESET;
        end else begin
            n.hc = r.hc + 10'h001;
        end

        // Blank ends at the wrap, returns after 32 segments
        if (n.hc == '0) begin
            n.blank = 1'b0;
        end else if (n.hc[`TPP_HC_BLANK_BIT]) begin
            n.blank = 1'b1;
        end

        // Fetch pair sits in the last two clocks before a segment
        vis_row = below(r.vc, `TPP_VC_VIS_END);
        seg     = n.hc + `TPP_HC_AHEAD;
        if (n.hc[`TPP_HC_BLANK_BIT]) begin
            fetch = n.hc[9:1] == `TPP_HC_LAST_PAIR;
        end else begin
            fetch = (n.hc[3:1] == `TPP_SEG_LAST) &
                    below(n.hc, `TPP_HC_FETCH_END);
        end
        fetch = fetch & vis_row & ~hs;
        n.vrd = fetch;

        // Character code comes back in the first fetch cycle
        if (r.vrd & ~r.hc[0]) begin
            n.chr = mem_rdata;
        end

        // Memory address for the coming fetch cycle
        if (fetch & ~n.hc[0]) begin
            n.addr = {`TPP_VID_BASE, r.vc[8:4], seg[8:4]};
        end else if (fetch) begin
            n.addr = {`TPP_GEN_BASE, n.chr[6:0],
                      r.vc[3:1]};
        end else begin
            n.addr = '0;
        end

        // Pixel shifter loads on the second fetch, shifts on odd counts
        if (r.vrd & r.hc[0]) begin
            n.shift = mem_rdata;
            n.ven   = ~below({3'h0, r.chr[6:0]},
                             {3'h0, `TPP_CHAR_MIN});
            n.hil   = r.chr[7];
        end else if (r.hc[0]) begin
            n.shift = {r.shift[6:0], 1'b0};
        end
        if (n.blank | ~vis_row) begin
            n.ven = 1'b0;
        end

        ////////////////////////////////////////////////////////////////////
        // Serial master, mode 0

        // Tick every clock when fast, twice per 256 when slow
        n.presc = (io_wr & (io_addr == `TPP_ADDR_SER)) ? '0
                  : r.presc + 7'h01;
        if (r.ctrl[`TPP_CTRL_FAST]) begin
            ser_tick = 1'b1;
        end else begin
            ser_tick = r.presc == `TPP_PRESC_MAX;
        end

        // Rising half samples, falling half shifts and advances busy
        if (busy & ser_tick & ~(io_wr & (io_addr == `TPP_ADDR_SER))) begin
            if (~r.sck) begin
                n.sck  = 1'b1;
                n.samp = r.miso_sy[1];
            end else begin
                n.sck  = 1'b0;
                n.sdat = {r.sdat[6:0], r.samp};
                n.sctl = {r.sctl[6:0], 1'b0};
                n.mosi = r.sdat[6];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            r <= TPP_STATE_RST;
        end else begin
            r <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, each a flop bit

    assign io_rdata         = r.rdata;
    assign rle_irq          = r.irq;
    assign tape_out         = r.tape_lvl;
    assign vid_read         = r.vrd;
    assign mem_addr         = r.addr;
    assign blanking         = r.blank;
    assign overlay_video_on = r.ven;
    assign pixel_out        = r.shift[7];
    assign highlight_out    = r.hil;
    assign sck_out          = r.sck;
    assign mosi_out         = r.mosi;

    // Control bits steer the outside world directly
    assign kbd_mute       = r.ctrl[`TPP_CTRL_MUTE];
    assign flash_select_n = r.ctrl[`TPP_CTRL_CS_FLASH];
    assign card_select_n  = r.ctrl[`TPP_CTRL_CS_CARD];

endmodule

`default_nettype wire

//--- dv/tpp_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

module tpp_mem_model (
    input  wire logic [12:0] mem_addr,
    output logic      [7:0]  mem_rdata
);
    ////////////////////////////////////////////////////////////////////////
    // Asynchronous RAM: odd text columns printable and highlighted,
    // even ones below the printable range; glyph bytes follow the address
    always_comb begin
        if (mem_addr[12:10] == 3'h7) begin
            mem_rdata = mem_addr[0] ? 8'hc1 : 8'h05;
        end else begin
            mem_rdata = mem_addr[7:0] ^ 8'h5a;
        end
    end
endmodule

`default_nettype wire

//--- dv/tpp_top_sva.sv
`timescale 1ns/1ps
`default_nettype none

module tpp_top_sva
    import tpp_pkg::*;
#(
    parameter int KBD_DEPTH = 16
) (
    input wire logic        mclk,
    input wire logic        sys_rst,
    input wire logic [1:0]  io_addr,
    input wire logic [7:0]  io_wdata,
    input wire logic        io_wr,
    input wire logic        io_rd,
    input wire logic [7:0]  io_rdata,
    input wire logic        rle_irq,
    input wire logic        vid_read,
    input wire logic [12:0] mem_addr,
    input wire logic [7:0]  mem_rdata,
    input wire logic        horiz_sync_in,
    input wire logic        blanking,
    input wire logic        overlay_video_on,
    input wire logic        sck_out,
    input wire logic        mosi_out,
    input wire logic        flash_select_n,
    input wire logic        card_select_n,
    input wire logic        kbd_mute
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    ////////////////////////////////////////////////////////////////////////
    // Video fetch pair
    a_fetch_len: assert property (
        $rose(vid_read) |=> vid_read ##1 !vid_read)
        else $error("fetch strobe not two cycles long");
    a_fetch_vid: assert property (
        $rose(vid_read) |-> mem_addr[12:10] == 3'h7)
        else $error("first fetch outside text area");
    a_fetch_gen: assert property (
        $rose(vid_read) |=> mem_addr[12:10] == 3'h0)
        else $error("second fetch outside glyph table");
    a_gen_code: assert property (
        $rose(vid_read) |=> mem_addr[9:3] == $past(mem_rdata[6:0]))
        else $error("glyph address not from fetched code");
    a_sync_blank: assert property (
        horiz_sync_in [*5] |-> blanking && !vid_read)
        else $error("line sync does not hold blanking");
    a_text_vis: assert property (
        overlay_video_on |-> !blanking)
        else $error("overlay shown during blanking");

    ////////////////////////////////////////////////////////////////////////
    // Control register, timer request and serial output
    a_sel_follow: assert property (
        io_wr && io_addr == 2'h0 |=> {kbd_mute, flash_select_n,
        card_select_n} == {$past(io_wdata[7]), $past(io_wdata[5:4])})
        else $error("control outputs do not follow write");
    a_ctrl_read: assert property (
        io_rd && io_addr == 2'h0 |=> io_rdata[7] == kbd_mute &&
        io_rdata[5:3] == {flash_select_n, card_select_n, 1'b0})
        else $error("control read does not match outputs");
    a_irq_hold: assert property (
        $fell(rle_irq) |-> $past(io_addr == 2'h3 && (io_wr || io_rd)))
        else $error("timer request dropped without access");
    a_mosi_fall: assert property (
        $changed(mosi_out) |-> !sck_out)
        else $error("serial output moved while clock high");

    c_irq: cover property ($rose(rle_irq));
    c_line: cover property ($fell(blanking));
    c_text: cover property ($rose(overlay_video_on));
    c_sck: cover property ($rose(sck_out));
endmodule

bind tpp_top tpp_top_sva #(.KBD_DEPTH(KBD_DEPTH)) u_sva (
    .mclk, .sys_rst, .io_addr, .io_wdata, .io_wr, .io_rd, .io_rdata,
    .rle_irq, .vid_read, .mem_addr, .mem_rdata, .horiz_sync_in, .blanking,
    .overlay_video_on, .sck_out, .mosi_out, .flash_select_n,
    .card_select_n, .kbd_mute
);

`default_nettype wire

//--- dv/tpp_top_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("[FAIL] %0t value mismatch", $time); end end

module tpp_top_test;
    import tpp_pkg::*;
    localparam int KBD_N = 16;
    logic        mclk, sys_rst, io_wr, io_rd, ok, tape_in, motor_in;
    logic        sample_tick_in, miso_in, kbd_code_valid;
    logic        horiz_sync_in = 1'b0, vert_sync_in = 1'b0;
    logic [1:0]  io_addr;
    logic [7:0]  io_wdata, kbd_code, io_rdata, mem_rdata, rnd, mosi_cap;
    logic [12:0] mem_addr;
    logic        rle_irq, vid_read, blanking, overlay_video_on, pixel_out;
    logic        highlight_out, tape_out, sck_out, mosi_out, flash_select_n;
    logic        card_select_n, kbd_mute, kbd_code_ready;
    logic        rd_d = 1'b0, sck_d = 1'b0, vr_d = 1'b0;
    logic [15:0] exp_q[$];
    logic [7:0]  kq[$];
    int          error_cnt = 0, n_checks = 0, hcnt = 0, line = 0, t, k, r0;
    int          fetch_n = 0, fetch_last = 0, ovl_n = 0, ovl_last = 0;
    int          sck_rises = 0, hi_len = 0, hi_last = 0;
    int          pix_n = 0, pix_last = 0, hil_n = 0, hil_last = 0;
    int          pix_row = 0;

    tpp_top #(.KBD_DEPTH(KBD_N)) dut (
        .mclk, .sys_rst, .io_addr, .io_wdata, .io_wr, .io_rd, .io_rdata,
        .rle_irq, .vid_read, .mem_addr, .mem_rdata, .horiz_sync_in,
        .vert_sync_in, .blanking, .overlay_video_on, .pixel_out,
        .highlight_out, .sample_tick_in, .tape_in, .tape_out, .motor_in,
        .miso_in, .sck_out, .mosi_out, .flash_select_n, .card_select_n,
        .kbd_mute, .kbd_code, .kbd_code_valid, .kbd_code_ready
    );
    tpp_mem_model u_mem (.mem_addr, .mem_rdata);

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////
    // Sync stimulus and per-line fetch and overlay counts
    always @(posedge mclk) begin
        hcnt <= (hcnt == 799) ? 0 : hcnt + 1;
        if (hcnt == 799) line <= (line == 7) ? 0 : line + 1;
        horiz_sync_in <= (hcnt < 8);
        vert_sync_in <= (hcnt < 8) && (line == 0);
        vr_d <= vid_read;
        fetch_n <= (hcnt == 0) ? 0 : fetch_n + int'(vid_read && !vr_d);
        ovl_n <= (hcnt == 0) ? 0 : ovl_n + int'(overlay_video_on);
        if (hcnt == 0) fetch_last <= fetch_n;
        if (hcnt == 0) ovl_last <= ovl_n;
        pix_n <= (hcnt == 0) ? 0
                 : pix_n + int'(pixel_out && overlay_video_on);
        hil_n <= (hcnt == 0) ? 0
                 : hil_n + int'(highlight_out && overlay_video_on);
        if (hcnt == 0) pix_last <= pix_n;
        if (hcnt == 0) hil_last <= hil_n;
        if (hcnt == 0) pix_row <= ((line + 7) % 8) / 2;
    end

    // Serial clock: count rises, capture output bit, time the high phase
    always @(posedge mclk) begin
        sck_d <= sck_out;
        if (sck_out && !sck_d) sck_rises <= sck_rises + 1;
        if (sck_out && !sck_d) mosi_cap <= {mosi_cap[6:0], mosi_out};
        hi_len <= sck_out ? hi_len + 1 : 0;
        if (!sck_out && sck_d) hi_last <= hi_len;
    end

    // Read answers against the oldest expectation
    always @(posedge mclk) begin
        if (rd_d && exp_q.size() > 0) begin
            if (exp_q[0][15:8] != 8'h00)
                `CHK(io_rdata & exp_q[0][15:8], exp_q[0][7:0])
            void'(exp_q.pop_front());
        end
        rd_d <= io_rd;
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic wrap_up();
        $display("errors %0d checks %0d", error_cnt, n_checks);
        if (error_cnt == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge mclk);
        io_addr <= a;
        io_wdata <= d;
        io_wr <= 1'b1;
        @(posedge mclk);
        io_wr <= 1'b0;
    endtask

    // Expectation is noted with its mask; a zero mask is not compared
    task automatic rd(input logic [1:0] a, input logic [7:0] e, m);
        @(posedge mclk);
        io_addr <= a;
        io_rd <= 1'b1;
        exp_q.push_back({m, e & m});
        @(posedge mclk);
        io_rd <= 1'b0;
    endtask

    // Host polls busy before taking received data
    task automatic wait_idle();
        for (k = 0; k < 1000; k++) begin
            rd(2'h0, 8'h00, 8'h00);
            @(posedge mclk);
            if (io_rdata[1] === 1'b0) return;
        end
        error_cnt++;
        $display("[FAIL] %0t serial transfer never ended", $time);
        wrap_up();
    endtask

    task automatic pulse();
        @(posedge mclk);
        sample_tick_in <= 1'b1;
        repeat (2) @(posedge mclk);
        sample_tick_in <= 1'b0;
        repeat (6) @(posedge mclk);
    endtask

    task automatic run(output int n);
        for (n = 1; n <= 20; n++) begin
            pulse();
            if (rle_irq === 1'b1) return;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {io_wr, io_rd, sample_tick_in, tape_in, miso_in} = '0;
        {kbd_code_valid, io_addr, io_wdata, kbd_code} = '0;
        motor_in = 1'b1;
        sys_rst = 1'b1;
        rnd = 8'h36;
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        `CHK({flash_select_n, card_select_n, blanking}, 3'b111)
        `CHK(kbd_code_ready, 1'b1)
        rd(2'h0, 8'h34, 8'hff);
        for (int i = 0; i < 4; i++) begin
            wr(2'h0, rnd);
            rd(2'h0, {rnd[7:4], 4'h4}, 8'hff);
            rnd = lfsr(rnd);
        end
        // Fill the scancode queue until refused, then drain it
        wr(2'h2, 8'h55);
        kbd_code <= rnd;
        kbd_code_valid <= 1'b1;
        repeat (20) begin
            #1 ok = (kbd_code_ready === 1'b1);
            @(posedge mclk);
            if (!ok) break;
            kq.push_back(kbd_code);
            rnd = lfsr(rnd);
            kbd_code <= rnd;
        end
        kbd_code_valid <= 1'b0;
        `CHK(kq.size(), KBD_N)
        rd(2'h0, 8'h01, 8'h01);
        while (kq.size() > 0) rd(2'h2, kq.pop_front(), 8'hff);
        rd(2'h0, 8'h00, 8'h01);
        // Fast transfer with input high, then a slow one with input low
        wr(2'h0, 8'h40);
        miso_in <= 1'b1;
        r0 = sck_rises;
        wr(2'h1, rnd);
        wait_idle();
        `CHK(sck_rises - r0, 8)
        `CHK(mosi_cap, rnd)
        `CHK(hi_last, 1)
        rd(2'h1, 8'hff, 8'hff);
        wr(2'h0, 8'h00);
        miso_in <= 1'b0;
        rnd = lfsr(rnd);
        wr(2'h1, rnd);
        wait_idle();
        `CHK(hi_last, 128)
        `CHK(mosi_cap, rnd)
        rd(2'h1, 8'h00, 8'hff);
        // Playback run lengths, then one recorded edge
        wr(2'h3, 8'h83);
        run(t);
        `CHK(tape_out, 1'b1)
        wr(2'h3, 8'h05);
        run(t);
        `CHK(t, 3)
        `CHK(tape_out, 1'b0)
        wr(2'h3, 8'h7f);
        run(t);
        `CHK(t, 5)
        wr(2'h3, 8'h7f);
        repeat (5) pulse();
        `CHK(rle_irq, 1'b0)
        tape_in <= 1'b1;
        repeat (6) @(posedge mclk);
        `CHK(rle_irq, 1'b1)
        rd(2'h3, 8'hfa, 8'hff);
        @(posedge mclk);
        `CHK(rle_irq, 1'b0)
        `CHK(fetch_last, 32)
        `CHK(ovl_last, 256)
        `CHK(hil_last, 256)
        `CHK(pix_last, 32 * $countones((8'h08 | 8'(pix_row)) ^ 8'h5a))
        wrap_up();
    end
endmodule

`default_nettype wire
